// File: inc/irq_status_pkg.sv
/*
 Constants of the adapter interrupt and main-status unit: register offsets,
 status bit positions, command codes and reset values.
 Assumes the host command decoder hands over decoded commands as pulses.
*/
package irq_status_pkg;
   // Register offsets inside their windows
   localparam logic [3:0]  SRC_MASK_OFFSET    = 4'ha;
   localparam logic [3:0]  STATUS_OFFSET      = 4'he;
   localparam logic [2:0]  MASK_WINDOW        = 3'h5;
   // Status bit positions
   localparam int          BIT_IRQ            = 0;
   localparam int          BIT_MISUSE         = 1;
   localparam int          BIT_SEND_DONE      = 2;
   localparam int          BIT_SEND_SPACE     = 3;
   localparam int          BIT_FRAME_ARRIVED  = 4;
   localparam int          BIT_PARTIAL        = 5;
   localparam int          BIT_SOFT_IRQ       = 6;
   localparam int          BIT_NEAR_FULL      = 7;
   localparam int          BIT_DMA_DONE       = 8;
   localparam int          BIT_DMA_ACTIVE     = 11;
   localparam int          BIT_CMD_EXEC       = 12;
   localparam int          BIT_WIN_LO         = 13;
   // Interrupt-causing sources occupy bits 7..1
   localparam logic [15:0] SOURCE_BITS        = 16'h00fe;
   // Bits that an acknowledge may clear
   localparam logic [15:0] ACK_BITS           = 16'h0069;
   // Reset values
   localparam logic [15:0] MASK_RESET         = 16'h0000;
   localparam logic [15:0] STATUS_RESET       = 16'h0000;
   localparam logic [2:0]  WINDOW_RESET       = 3'h0;
   // Command opcodes on the 5-bit command field
   localparam logic [4:0]  OP_GLOBAL_RESET    = 5'h00;
   localparam logic [4:0]  OP_SELECT_WINDOW   = 5'h01;
   localparam logic [4:0]  OP_CLEAR_EVENT     = 5'h0d;
   localparam logic [4:0]  OP_SOFT_IRQ        = 5'h0c;
   localparam logic [4:0]  OP_LOAD_IRQ_MASK   = 5'h0e;
   localparam logic [4:0]  OP_LOAD_VIS_MASK   = 5'h0f;
   localparam logic [4:0]  OP_BEGIN_TRANSFER  = 5'h14;
   localparam logic [4:0]  OP_DROP_TOP_FRAME  = 5'h08;
   // Cycles a command stays in execution
   localparam logic [3:0]  CMD_BUSY_CYCLES    = 4'h3;
endpackage

// File: logic/cmd_tracker.sv
/*
 Command execution tracker: holds the busy flag for a fixed number of
 cycles after each command and latches the visible window number.
 Assumes commands arrive as one-cycle strobes on the system clock.
*/
`timescale 1ns/10ps
module cmd_tracker (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       sys_rst,
   // Command strobe
   input  wire logic       cmd_strobe,
   input  wire logic [4:0] cmd_op,
   input  wire logic [2:0] cmd_arg,
   // State out
   output logic            cmd_executing_flag,
   output logic [2:0]      visible_bank_index
);
   logic [3:0] busy_cnt;
   logic [3:0] next_busy_cnt;
   logic [2:0] next_bank;

   always_comb begin
      next_busy_cnt = busy_cnt;
      next_bank     = visible_bank_index;
      if (busy_cnt != 4'h0) begin
         next_busy_cnt = busy_cnt - 4'h1;
      end
      if (cmd_strobe) begin
         next_busy_cnt = irq_status_pkg::CMD_BUSY_CYCLES; // RL16
         if (cmd_op == irq_status_pkg::OP_SELECT_WINDOW) begin
            next_bank = cmd_arg;
         end
         if (cmd_op == irq_status_pkg::OP_GLOBAL_RESET) begin
            next_bank = irq_status_pkg::WINDOW_RESET; // RL17
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         busy_cnt           <= 4'h0;
         visible_bank_index <= irq_status_pkg::WINDOW_RESET;
         cmd_executing_flag <= 1'b0;
      end else begin
         busy_cnt           <= next_busy_cnt;
         visible_bank_index <= next_bank;
         cmd_executing_flag <= (next_busy_cnt != 4'h0);
      end
   end

   AST_BUSY_AFTER_CMD: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL16
      cmd_strobe |=> cmd_executing_flag [*3] ##1 (!cmd_executing_flag || $past(cmd_strobe)))
      else $error("busy flag length wrong");
endmodule

// File: logic/adapter_interrupt_status_unit.sv
/*
 Interrupt and main-status unit of a bus-master network adapter: sticky
 event bits, visibility and interrupt masks, bus interrupt and status read.
 Assumes the host register decoder supplies command strobes with opcode and
 11-bit argument, and register read selects by window and offset.
*/
//
// Function
// [RL1] Interrupt mask bit gates its status bit onto the bus interrupt.
// [RL2] Interrupt mask reads only; loaded solely by the mask-load command.
// [RL3] Interrupt mask clears to zero on reset.
// [RL4] Bits 1-7 are sources, maskable for interrupt, hidden by visibility mask.
// [RL5] Whole status word clears on reset.
// [RL6] Bit 0 is OR of masked sources; cleared by acknowledge flag.
// [RL7] Bit 1 sets on FIFO misuse; clears on transmitter or receiver reset.
// [RL8] Bit 2 sets on notified send or send error; clears on result write.
// [RL9] Bit 3 sets when send space exceeds threshold; acknowledge clears.
// [RL10] Bit 4 holds while complete frames remain; drop commands clear it.
// [RL11] Bit 5 sets past early threshold; drops on full reception; acknowledge clears.
// [RL12] Bit 6 sets on soft interrupt command; acknowledge clears.
// [RL13] Bit 7 sets when counters near full; clears after all are read.
// [RL14] Bit 8 sets on transfer end; clears when both done flags clear.
// [RL15] Bit 11 set by transfer start command until transfer completes.
// [RL16] Bit 12 set while a command executes; host waits for zero.
// [RL17] Bits 15-13 show window; reset and global reset return zero.
// [RL18] Visibility mask permits bits to set; loaded by command, reset clears.
// [RL19] Bits 10 and 9 read zero; status readable in every window.
// [RL20] Acknowledge clears only flagged bits.
`timescale 1ns/10ps
module adapter_interrupt_status_unit #(
   parameter int STATUS_W = 16
) (
   // Clock and reset
   input  wire logic                sys_clk,
   input  wire logic                sys_rst,
   // Host command strobe
   input  wire logic                cmd_strobe,
   input  wire logic [4:0]          cmd_op,
   input  wire logic [10:0]         cmd_arg,
   // Host register read
   input  wire logic                reg_read,
   input  wire logic [3:0]          reg_offset,
   output logic [15:0]              reg_rdata,
   // FIFO misuse, path resets and transmit path events
   input  wire logic                transmit_write_port_overrun,
   input  wire logic                receive_read_underrun,
   input  wire logic                tx_reset_pulse,
   input  wire logic                rx_reset_pulse,
   input  wire logic                send_ok_pulse,
   input  wire logic                send_notify_request,
   input  wire logic                send_error_pulse,
   input  wire logic                send_result_fifo_write,
   input  wire logic                send_space_above_threshold,
   // Receive path state
   input  wire logic                complete_frames_present,
   input  wire logic                top_frame_past_threshold,
   input  wire logic                top_frame_complete,
   // Statistics and bus master
   input  wire logic                counters_near_full_pulse,
   input  wire logic                all_counters_read_pulse,
   input  wire logic                dma_end_pulse,
   input  wire logic                dma_to_host_done,
   input  wire logic                dma_from_host_done,
   // Outputs
   output logic                     bus_irq,
   output logic [STATUS_W-1:0]      main_status_word,
   output logic [STATUS_W-1:0]      source_interrupt_mask,
   output logic [STATUS_W-1:0]      status_visibility_mask
);
   logic [15:0] events;
   logic [15:0] next_events;
   logic [15:0] next_irq_mask;
   logic [15:0] next_vis_mask;
   logic [15:0] next_status;
   logic [15:0] next_rdata;
   logic        next_irq;
   logic        next_dma_active;
   logic        dma_active_flag;
   logic        cmd_executing_flag;
   logic [2:0]  visible_bank_index;
   logic [15:0] ack_clear;
   logic        is_cmd;

   function automatic logic cmd_is(input logic [4:0] op, input logic [4:0] code);
      cmd_is = (op == code);
   endfunction

   cmd_tracker u_cmd_tracker (
      .sys_clk            (sys_clk),
      .sys_rst            (sys_rst),
      .cmd_strobe         (cmd_strobe),
      .cmd_op             (cmd_op),
      .cmd_arg            (cmd_arg[2:0]),
      .cmd_executing_flag (cmd_executing_flag),
      .visible_bank_index (visible_bank_index)
   );

   always_comb begin
      is_cmd        = cmd_strobe;
      next_events   = events;
      next_irq_mask = source_interrupt_mask;
      next_vis_mask = status_visibility_mask;
      next_dma_active = dma_active_flag;
      ack_clear     = 16'h0000;
      if (is_cmd && cmd_is(cmd_op, irq_status_pkg::OP_CLEAR_EVENT)) begin
         ack_clear = {5'h00, cmd_arg} & irq_status_pkg::ACK_BITS; // RL20
      end
      // Clears first so that a simultaneous set wins
      next_events = next_events & ~ack_clear; // RL9 RL11 RL12
      if (tx_reset_pulse || rx_reset_pulse) begin
         next_events[irq_status_pkg::BIT_MISUSE] = 1'b0; // RL7
      end
      if (send_result_fifo_write) begin
         next_events[irq_status_pkg::BIT_SEND_DONE] = 1'b0; // RL8
      end
      if (all_counters_read_pulse) begin
         next_events[irq_status_pkg::BIT_NEAR_FULL] = 1'b0; // RL13
      end
      if (!dma_to_host_done && !dma_from_host_done) begin
         next_events[irq_status_pkg::BIT_DMA_DONE] = 1'b0; // RL14
      end
      if (top_frame_complete) begin
         next_events[irq_status_pkg::BIT_PARTIAL] = 1'b0; // RL11
      end
      // Sets; source bits 7..1 are gated by the visibility mask, bit 8 is not
      if (transmit_write_port_overrun || receive_read_underrun) begin
         next_events[irq_status_pkg::BIT_MISUSE] = 1'b1; // RL7
      end
      if ((send_ok_pulse && send_notify_request) || send_error_pulse) begin
         next_events[irq_status_pkg::BIT_SEND_DONE] = 1'b1; // RL8
      end
      if (send_space_above_threshold) begin
         next_events[irq_status_pkg::BIT_SEND_SPACE] = 1'b1; // RL9
      end
      // Frame-present bit follows the FIFO level, so draining it by drops clears it
      next_events[irq_status_pkg::BIT_FRAME_ARRIVED] = complete_frames_present; // RL10
      if (top_frame_past_threshold && !top_frame_complete) begin
         next_events[irq_status_pkg::BIT_PARTIAL] = 1'b1; // RL11
      end
      if (is_cmd && cmd_is(cmd_op, irq_status_pkg::OP_SOFT_IRQ)) begin
         next_events[irq_status_pkg::BIT_SOFT_IRQ] = 1'b1; // RL12
      end
      if (counters_near_full_pulse) begin
         next_events[irq_status_pkg::BIT_NEAR_FULL] = 1'b1; // RL13
      end
      if (dma_end_pulse) begin
         next_events[irq_status_pkg::BIT_DMA_DONE] = 1'b1; // RL14
         next_dma_active = 1'b0; // RL15
      end
      if (is_cmd && cmd_is(cmd_op, irq_status_pkg::OP_BEGIN_TRANSFER)) begin
         next_dma_active = 1'b1; // RL15
      end
      next_events = next_events & (next_vis_mask | ~irq_status_pkg::SOURCE_BITS) // RL18 RL4
                  & 16'h01fe;
      if (is_cmd && cmd_is(cmd_op, irq_status_pkg::OP_LOAD_IRQ_MASK)) begin
         next_irq_mask = {5'h00, cmd_arg}; // RL2
      end
      if (is_cmd && cmd_is(cmd_op, irq_status_pkg::OP_LOAD_VIS_MASK)) begin
         next_vis_mask = {5'h00, cmd_arg}; // RL18
      end
      // Latch bit holds until acknowledged, re-asserted by any masked source
      next_irq = (bus_irq && !ack_clear[irq_status_pkg::BIT_IRQ])
               || |(next_events & next_irq_mask & irq_status_pkg::SOURCE_BITS); // RL1 RL6
      next_status = next_events;
      next_status[irq_status_pkg::BIT_IRQ]        = next_irq; // RL6
      next_status[irq_status_pkg::BIT_DMA_ACTIVE] = next_dma_active;
      next_status[irq_status_pkg::BIT_CMD_EXEC]   = cmd_executing_flag; // RL16
      next_status[15:irq_status_pkg::BIT_WIN_LO]  = visible_bank_index; // RL17
      next_status[10:9] = 2'b00; // RL19
      next_rdata = 16'h0000;
      if (reg_read) begin
         if (reg_offset == irq_status_pkg::STATUS_OFFSET) begin
            next_rdata = main_status_word; // RL19
         end else if (reg_offset == irq_status_pkg::SRC_MASK_OFFSET
                      && visible_bank_index == irq_status_pkg::MASK_WINDOW) begin
            next_rdata = source_interrupt_mask; // RL2
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         events                 <= irq_status_pkg::STATUS_RESET;
         source_interrupt_mask  <= irq_status_pkg::MASK_RESET; // RL3
         status_visibility_mask <= irq_status_pkg::MASK_RESET; // RL18
         main_status_word       <= irq_status_pkg::STATUS_RESET; // RL5
         bus_irq                <= 1'b0;
         dma_active_flag        <= 1'b0;
         reg_rdata              <= 16'h0000;
      end else begin
         events                 <= next_events;
         source_interrupt_mask  <= next_irq_mask;
         status_visibility_mask <= next_vis_mask;
         main_status_word       <= next_status;
         bus_irq                <= next_irq;
         dma_active_flag        <= next_dma_active;
         reg_rdata              <= next_rdata;
      end
   end

   sequence soft_irq_cmd_s;
      cmd_strobe && cmd_op == irq_status_pkg::OP_SOFT_IRQ;
   endsequence

   AST_MASK_ZERO_NO_IRQ: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL1
      (source_interrupt_mask == 16'h0000 && !bus_irq) |=> !bus_irq
         || $past(cmd_strobe))
      else $error("interrupt without enabled source");
   AST_MASK_ONLY_BY_CMD: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL2
      !(cmd_strobe && cmd_op == irq_status_pkg::OP_LOAD_IRQ_MASK)
         |=> $stable(source_interrupt_mask))
      else $error("mask changed without load command");
   AST_RESET_CLEARS: assert property (@(posedge sys_clk) // RL5
      sys_rst |=> main_status_word == 16'h0000 && source_interrupt_mask == 16'h0000)
      else $error("reset did not clear state");
   AST_RESERVED_ZERO: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL19
      main_status_word[10:9] == 2'b00)
      else $error("reserved status bits set");
   AST_HIDDEN_SOURCE: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL4
      ((main_status_word & ~status_visibility_mask & 16'h00fe) == 16'h0000)
         || $past(cmd_strobe))
      else $error("hidden source visible");
   AST_SOFT_IRQ_SETS: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL12
      soft_irq_cmd_s ##0 status_visibility_mask[6] |=> ##1 main_status_word[6])
      else $error("soft interrupt bit not set");
   AST_IRQ_MIRROR: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL6
      main_status_word[0] == bus_irq)
      else $error("status bit 0 differs from interrupt");
   AST_DMA_ACTIVE: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL15
      (cmd_strobe && cmd_op == irq_status_pkg::OP_BEGIN_TRANSFER && !dma_end_pulse)
         |=> ##1 main_status_word[11])
      else $error("transfer start not shown");

   // Command strobes as the next-state logic decodes them
   sequence load_irq_mask_cmd_s;
      cmd_strobe && cmd_op == irq_status_pkg::OP_LOAD_IRQ_MASK;
   endsequence
   sequence load_vis_mask_cmd_s;
      cmd_strobe && cmd_op == irq_status_pkg::OP_LOAD_VIS_MASK;
   endsequence
   sequence global_reset_cmd_s;
      cmd_strobe && cmd_op == irq_status_pkg::OP_GLOBAL_RESET;
   endsequence
   sequence clear_event_cmd_s;
      cmd_strobe && cmd_op == irq_status_pkg::OP_CLEAR_EVENT;
   endsequence

   AST_IRQ_MASK_LOAD: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL2
      load_irq_mask_cmd_s |=> source_interrupt_mask == {5'h00, $past(cmd_arg)})
      else $error("interrupt mask not loaded");
   AST_VIS_MASK_LOAD: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL18
      load_vis_mask_cmd_s |=> status_visibility_mask == {5'h00, $past(cmd_arg)})
      else $error("visibility mask not loaded");
   AST_ACK_CLEARS_SOFT: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL20
      clear_event_cmd_s ##0 cmd_arg[6] |=> !main_status_word[6])
      else $error("acknowledged soft interrupt still set");
   AST_BUSY_SHOWN: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL16
      cmd_strobe |=> ##1 main_status_word[12])
      else $error("busy bit not shown in status");
   AST_WINDOW_HOME: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL17
      global_reset_cmd_s |=> ##1 main_status_word[15:13] == irq_status_pkg::WINDOW_RESET)
      else $error("window not returned to zero");
   // A hidden source may stay clear; except on the partial bit, a set beats a clear in the same cycle
   AST_MISUSE_SETS: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL7
      (transmit_write_port_overrun || receive_read_underrun)
         |=> main_status_word[1] || !status_visibility_mask[1])
      else $error("misuse bit not set");
   AST_MISUSE_HOLDS: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL7
      (main_status_word[1] && !tx_reset_pulse && !rx_reset_pulse)
         |=> main_status_word[1] || !status_visibility_mask[1])
      else $error("misuse bit cleared without path reset");
   AST_SEND_DONE_SETS: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL8
      ((send_ok_pulse && send_notify_request) || send_error_pulse)
         |=> main_status_word[2] || !status_visibility_mask[2])
      else $error("send done bit not set");
   AST_SEND_DONE_CLEARS: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL8
      (send_result_fifo_write && !send_error_pulse && !(send_ok_pulse && send_notify_request))
         |=> !main_status_word[2])
      else $error("send done bit not cleared by result write");
   AST_SPACE_SETS: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL9
      send_space_above_threshold |=> main_status_word[3] || !status_visibility_mask[3])
      else $error("send space bit not set");
   AST_FRAME_PRESENT: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL10
      complete_frames_present |=> main_status_word[4] == status_visibility_mask[4])
      else $error("frame present bit wrong");
   AST_FRAME_DRAINED: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL10
      !complete_frames_present |=> !main_status_word[4])
      else $error("frame present bit stuck after drain");
   AST_PARTIAL_SETS: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL11
      (top_frame_past_threshold && !top_frame_complete)
         |=> main_status_word[5] || !status_visibility_mask[5])
      else $error("partial frame bit not set");
   AST_PARTIAL_DROPS: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL11
      top_frame_complete |=> !main_status_word[5])
      else $error("partial frame bit kept after full reception");
   AST_NEAR_FULL_SETS: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL13
      counters_near_full_pulse |=> main_status_word[7] || !status_visibility_mask[7])
      else $error("counters near full bit not set");
   AST_DMA_DONE_SETS: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL14
      (dma_end_pulse && !(cmd_strobe && cmd_op == irq_status_pkg::OP_BEGIN_TRANSFER))
         |=> main_status_word[8] && !main_status_word[11])
      else $error("transfer end not shown");
   AST_DMA_DONE_CLEARS: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL14
      (!dma_end_pulse && !dma_to_host_done && !dma_from_host_done)
         |=> !main_status_word[8])
      else $error("transfer done bit kept after both flags cleared");
endmodule

// File: test/host_cmd_model.sv
/*
 Host driver model: issues one command at a time on the command strobe and
 then polls the busy bit of the status word before it returns.
 Assumes the status word is registered and the caller runs on the bench clock.
*/
`timescale 1ns/10ps
module host_cmd_model (
   // Clock
   input  wire logic        sys_clk,
   // Status seen by the host
   input  wire logic [15:0] status,
   // Command strobe
   output logic             cmd_strobe,
   output logic [4:0]       cmd_op,
   output logic [10:0]      cmd_arg
);
   initial begin
      cmd_strobe = 1'b0;
      cmd_op     = 5'h00;
      cmd_arg    = 11'h000;
   end

   // Masks change only through these commands, never by a register write
   task automatic issue(input logic [4:0] op, input logic [10:0] arg, output int busy);
      @(negedge sys_clk);
      cmd_strobe = 1'b1;
      cmd_op     = op;
      cmd_arg    = arg;
      @(negedge sys_clk);
      cmd_strobe = 1'b0;
      // Unqualified fields do not keep the old value
      cmd_op     = ~op;
      cmd_arg    = ~arg;
      // The status word is registered, so bit 12 shows one cycle after the flag
      @(negedge sys_clk);
      busy       = 0;
      while (status[12] === 1'b1 && busy < 20) begin
         busy++;
         @(negedge sys_clk);
      end
   endtask
endmodule

// File: test/adapter_interrupt_status_unit_tb.sv
/*
 Self-checking bench of the interrupt and main-status unit: directed command
 sequences plus random event traffic compared with a behavioural model.
 Assumes the host model in host_cmd_model and the package constants.
*/
`timescale 1ns/10ps
module adapter_interrupt_status_unit_tb;
   logic        sys_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        reg_read = 1'b0;
   logic [3:0]  reg_offset = 4'h0;
   logic [16:0] ev = 17'h00000;
   logic        cmd_strobe;
   logic [4:0]  cmd_op;
   logic [10:0] cmd_arg;
   logic [15:0] reg_rdata, status, src_mask, vis_mask, exp;
   logic        bus_irq;
   logic [10:0] m;
   logic [15:0] vm = 16'h0000;
   int          fail_count = 0, total_checks = 0, cycles = 0, b;

   always #12.5 sys_clk = ~sys_clk;

   host_cmd_model host_cmd_model_i (.sys_clk(sys_clk), .status(status),
      .cmd_strobe(cmd_strobe), .cmd_op(cmd_op), .cmd_arg(cmd_arg));

   adapter_interrupt_status_unit adapter_interrupt_status_unit_i (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_strobe(cmd_strobe), .cmd_op(cmd_op),
      .cmd_arg(cmd_arg), .reg_read(reg_read), .reg_offset(reg_offset),
      .reg_rdata(reg_rdata), .transmit_write_port_overrun(ev[0]),
      .receive_read_underrun(ev[1]), .tx_reset_pulse(ev[2]), .rx_reset_pulse(ev[3]),
      .send_ok_pulse(ev[4]), .send_notify_request(ev[5]), .send_error_pulse(ev[6]),
      .send_result_fifo_write(ev[7]), .send_space_above_threshold(ev[8]),
      .complete_frames_present(ev[9]), .top_frame_past_threshold(ev[10]),
      .top_frame_complete(ev[11]), .counters_near_full_pulse(ev[12]),
      .all_counters_read_pulse(ev[13]), .dma_end_pulse(ev[14]),
      .dma_to_host_done(ev[15]), .dma_from_host_done(ev[16]), .bus_irq(bus_irq),
      .main_status_word(status), .source_interrupt_mask(src_mask),
      .status_visibility_mask(vis_mask));

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] want);
      total_checks++;
      if (seen !== want) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, want, seen);
      end
   endtask

   // Sticky event bits gated by the expected visibility mask; set wins over clear,
   // except that full reception of the top frame drops the partial bit
   function automatic logic [15:0] nxt(input logic [15:0] s, input logic [16:0] e);
      logic [15:0] n;
      n = s;
      if (e[0] | e[1]) n[1] = 1'b1; else if (e[2] | e[3]) n[1] = 1'b0;
      if ((e[4] & e[5]) | e[6]) n[2] = 1'b1; else if (e[7]) n[2] = 1'b0;
      if (e[8]) n[3] = 1'b1;
      n[4] = e[9];
      if (e[11]) n[5] = 1'b0; else if (e[10]) n[5] = 1'b1;
      if (e[12]) n[7] = 1'b1; else if (e[13]) n[7] = 1'b0;
      if (e[14]) begin
         n[8]  = 1'b1;
         n[11] = 1'b0;
      end else if (!e[15] && !e[16]) n[8] = 1'b0;
      return n & (vm | ~16'h00fe);
   endfunction

   // Random events; a pulse fires about one cycle in eight
   task automatic traffic(input int n, input logic [15:0] care);
      repeat (n) begin
         @(negedge sys_clk);
         chk("status", status & care, exp & care);
         for (int i = 0; i < 17; i++) ev[i] = ($urandom % 8) == 0;
         exp = nxt(exp, ev);
      end
      @(negedge sys_clk);
      ev  = 17'h00000;
      exp = nxt(exp, ev);
      @(negedge sys_clk);
   endtask

   task automatic rd(input logic [3:0] off, input logic [15:0] want);
      @(negedge sys_clk);
      reg_read   = 1'b1;
      reg_offset = off;
      @(negedge sys_clk);
      reg_read   = 1'b0;
      chk("reg_rdata", reg_rdata, want);
   endtask

   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         stop_test();
      end
   end

   initial begin
      void'($urandom(32'hbd79077c));
      repeat (16) @(negedge sys_clk);
      chk("status", status, irq_status_pkg::STATUS_RESET);
      chk("irq mask", src_mask, irq_status_pkg::MASK_RESET);
      chk("vis mask", vis_mask, 16'h0000);
      sys_rst = 1'b0;
      host_cmd_model_i.issue(irq_status_pkg::OP_LOAD_VIS_MASK, 11'h7ff, b);
      vm = 16'h07ff;
      chk("vis mask", vis_mask, 16'h07ff);
      chk("busy cycles", 16'(b), 16'(irq_status_pkg::CMD_BUSY_CYCLES));
      host_cmd_model_i.issue(irq_status_pkg::OP_SOFT_IRQ, 11'h000, b);
      chk("status", status, 16'h0040);
      chk("bus_irq", {15'h0, bus_irq}, 16'h0000);
      host_cmd_model_i.issue(irq_status_pkg::OP_LOAD_IRQ_MASK, 11'h040, b);
      chk("irq mask", src_mask, 16'h0040);
      repeat (2) @(negedge sys_clk);
      chk("status", status, 16'h0041);
      chk("bus_irq", {15'h0, bus_irq}, 16'h0001);
      host_cmd_model_i.issue(irq_status_pkg::OP_CLEAR_EVENT, 11'h040, b);
      chk("status", status, 16'h0001);
      host_cmd_model_i.issue(irq_status_pkg::OP_CLEAR_EVENT, 11'h001, b);
      chk("status", status, 16'h0000);
      chk("bus_irq", {15'h0, bus_irq}, 16'h0000);
      host_cmd_model_i.issue(irq_status_pkg::OP_BEGIN_TRANSFER, 11'h000, b);
      exp = 16'h0800;
      chk("status", status, exp);
      m = 11'($urandom);
      host_cmd_model_i.issue(irq_status_pkg::OP_LOAD_IRQ_MASK, m, b);
      traffic(300, 16'hfffe);
      host_cmd_model_i.issue(irq_status_pkg::OP_CLEAR_EVENT, 11'h069, b);
      exp    = exp & ~16'h0069;
      exp[0] = |(exp[7:1] & m[7:1]);
      chk("status", status, exp);
      chk("bus_irq", {15'h0, bus_irq}, {15'h0, exp[0]});
      host_cmd_model_i.issue(irq_status_pkg::OP_SELECT_WINDOW, 11'h003, b);
      exp[15:13] = 3'h3;
      rd(irq_status_pkg::STATUS_OFFSET, exp);
      host_cmd_model_i.issue(irq_status_pkg::OP_SELECT_WINDOW, 11'h005, b);
      exp[15:13] = irq_status_pkg::MASK_WINDOW;
      rd(irq_status_pkg::STATUS_OFFSET, exp);
      rd(irq_status_pkg::SRC_MASK_OFFSET, {5'h00, m});
      host_cmd_model_i.issue(irq_status_pkg::OP_GLOBAL_RESET, 11'h000, b);
      chk("window", 16'(status[15:13]), 16'h0000);
      // Second reset, nothing made visible: no source may set
      @(negedge sys_clk);
      sys_rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      sys_rst = 1'b0;
      vm      = 16'h0000;
      host_cmd_model_i.issue(irq_status_pkg::OP_LOAD_IRQ_MASK, 11'h7ff, b);
      exp = 16'h0000;
      traffic(60, 16'h01ff);
      chk("bus_irq", {15'h0, bus_irq}, 16'h0000);
      stop_test();
   end
endmodule
